// ===== hdl/pmsc_top.v
`timescale 1ns/1ns
`include "pmsc_defines.vh"
// Functional notes
// RULE_01: write is address, sub-address, data bytes
// RULE_02: host writes only sub-address zero
// RULE_03: device acks address, sub-address, data low
// RULE_04: data byte latched into holding register
// RULE_05: holding copied to active only at STOP
// RULE_06: read returns eight status bits, no STOP
// RULE_07: status captured when read address acked
// RULE_08: buck control clears on reset, UVLO, power-down
// RULE_09: bits zero, one, seven have no effect
// RULE_10: bits two..four select buck light-load mode
// RULE_11: bits six:five select common slew rate
// RULE_12: software should keep slew at fastest
// RULE_13: status bits three..seven are power-good
// RULE_14: status bits two:one encode charger fault
// RULE_15: status bit zero is constant-current charging
// RULE_16: reset to off; leave on button or hold
// RULE_17: power-up enables LDO2, buck1, buck2 in order
// RULE_18: one second after power-up enter powered
// RULE_19: powered exits on hold low or rail UVLO
// RULE_20: power-down clears registers, disables, waits second
// RULE_21: buck3 enable honoured only in up/powered
// RULE_22: button status low after 50ms, min 50ms
// RULE_23: slave address 0001001 plus read/write bit
// RULE_24: power-down wait ignores button and hold
// RULE_25: intervals counted from system clock
// RULE_26: button and hold inputs double-synchronised
module pmsc_top #(
  parameter CYC_50MS = `PMSC_CYC_50MS,
  parameter CYC_1S   = `PMSC_CYC_1S,
  parameter SEQ_STEP = `PMSC_SEQ_STEP
) (
  input  wire       ref_clk,              // 100 MHz system clock
  input  wire       reset_n,              // power-on reset, active low
  input  wire       interface_supply_uvlo, // interface supply undervoltage, high active
  input  wire       scl_in,               // serial clock pin
  input  wire       sda_in,               // serial data pin level
  output wire       sda_out,              // serial data drive value (always 0)
  output reg        sda_oe_n,             // low while pulling data line low
  input  wire       button_n_in,          // pushbutton, low when pressed
  input  wire       power_hold_in,        // power-hold from host
  input  wire       buck3_enable_in,      // buck3 enable request
  input  wire       vout_uvlo,            // output rail undervoltage
  input  wire [4:0] supply_good_in,       // ldo1,ldo2,buck1,buck2,buck3 in regulation
  input  wire [1:0] charger_fault_in,     // charger fault code
  input  wire       charging_in,          // charger in constant-current phase
  output reg        ldo2_en,              // LDO2 enable
  output reg        buck1_en,             // buck1 enable
  output reg        buck2_en,             // buck2 enable
  output reg        buck3_en,             // buck3 enable
  output reg        button_status_out,    // pushbutton status, low active
  output reg        buck1_light_load_sel, // 1 burst, 0 pulse skip
  output reg        buck2_light_load_sel, // 1 burst, 0 pulse skip
  output reg        buck3_light_load_sel, // 1 burst, 0 pulse skip
  output reg        slew_sel_lsb,         // slew select bit 0
  output reg        slew_sel_msb,         // slew select bit 1
  output reg  [3:0] pm_state              // one-hot power state
);

  localparam ST_OFF  = 4'b0001;
  localparam ST_UP   = 4'b0010;
  localparam ST_ON   = 4'b0100;
  localparam ST_DOWN = 4'b1000;

  localparam BS_IDLE = 5'b00001;
  localparam BS_ADDR = 5'b00010;
  localparam BS_SUB  = 5'b00100;
  localparam BS_DATA = 5'b01000;
  localparam BS_READ = 5'b10000;

  // synchronisers
  reg [1:0]  scl_s_reg, sda_s_reg, btn_s_reg, hold_s_reg;
  reg        scl_d_reg, sda_d_reg;
  // analog level flags cross too; each bit, including the two-bit charger fault code, is synchronised on its own
  reg [10:0] lvl_s0_reg, lvl_s1_reg;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_s_reg  <= 2'h3;
      sda_s_reg  <= 2'h3;
      btn_s_reg  <= 2'h3;
      hold_s_reg <= 2'h0;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
      lvl_s0_reg <= 11'h000;
      lvl_s1_reg <= 11'h000;
    end else begin
      scl_s_reg  <= {scl_s_reg[0], scl_in};
      sda_s_reg  <= {sda_s_reg[0], sda_in};
      btn_s_reg  <= {btn_s_reg[0], button_n_in};   // RULE_26
      hold_s_reg <= {hold_s_reg[0], power_hold_in}; // RULE_26
      scl_d_reg  <= scl_s_reg[1];
      sda_d_reg  <= sda_s_reg[1];
      lvl_s0_reg <= {interface_supply_uvlo, vout_uvlo, buck3_enable_in,
                     supply_good_in, charger_fault_in, charging_in};
      lvl_s1_reg <= lvl_s0_reg;
    end
  end

  wire scl      = scl_s_reg[1];
  wire sda      = sda_s_reg[1];
  wire pressed  = ~btn_s_reg[1];
  wire hold     = hold_s_reg[1];
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_c  = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_c   = scl & scl_d_reg & ~sda_d_reg & sda;
  wire iface_uvlo = lvl_s1_reg[10];
  wire vout_low   = lvl_s1_reg[9];
  wire b3_request = lvl_s1_reg[8];

  // serial slave
  reg [4:0] bs_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] sub_reg;
  reg [7:0] hold_data_reg;
  reg       hold_valid_reg;
  reg       ack_phase_reg;
  reg       tx_reg;
  wire      clear_regs = iface_uvlo | (pm_state == ST_DOWN);
  wire [7:0] status_byte = lvl_s1_reg[7:0]; // RULE_13 RULE_14 RULE_15

  assign sda_out = 1'b0;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bs_reg         <= BS_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      sub_reg        <= 8'h00;
      hold_data_reg  <= `PMSC_BUCK_RESET;
      hold_valid_reg <= 1'b0;
      ack_phase_reg  <= 1'b0;
      tx_reg         <= 1'b0;
      sda_oe_n       <= 1'b1;
    end else if (iface_uvlo) begin
      bs_reg         <= BS_IDLE;
      bit_cnt_reg    <= 4'h0;
      hold_valid_reg <= 1'b0;
      hold_data_reg  <= `PMSC_BUCK_RESET; // RULE_08
      ack_phase_reg  <= 1'b0;
      tx_reg         <= 1'b0;
      sda_oe_n       <= 1'b1;
    end else if (start_c) begin
      // repeated start keeps the holding register intact
      bs_reg        <= BS_ADDR; // RULE_05
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      tx_reg        <= 1'b0;
      sda_oe_n      <= 1'b1;
    end else if (stop_c) begin
      bs_reg         <= BS_IDLE;
      hold_valid_reg <= 1'b0;
      ack_phase_reg  <= 1'b0;
      tx_reg         <= 1'b0;
      sda_oe_n       <= 1'b1;
    end else begin
      if (clear_regs)
        hold_valid_reg <= 1'b0;
      if (scl_rise && !ack_phase_reg && !tx_reg && bs_reg != BS_IDLE) begin
        shift_reg   <= {shift_reg[6:0], sda};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (scl_fall) begin
        if (ack_phase_reg) begin
          // end of our ack clock: release, or start sending status
          ack_phase_reg <= 1'b0;
          bit_cnt_reg   <= 4'h0;
          if (bs_reg == BS_READ) begin
            tx_reg   <= 1'b1;
            sda_oe_n <= shift_reg[7];                    // RULE_06
            shift_reg <= {shift_reg[6:0], 1'b1};
          end else begin
            sda_oe_n <= 1'b1;
          end
        end else if (tx_reg) begin
          if (bit_cnt_reg == 4'h7) begin
            // eighth bit done: release for host ack, then go quiet
            tx_reg   <= 1'b0;
            sda_oe_n <= 1'b1;
            bs_reg   <= BS_IDLE;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            sda_oe_n    <= shift_reg[7];                 // RULE_06
            shift_reg   <= {shift_reg[6:0], 1'b1};
          end
        end else if (bit_cnt_reg == 4'h8) begin
          case (bs_reg)
            BS_ADDR: begin
              if (shift_reg[7:1] == `PMSC_SLAVE_ADDR) begin // RULE_23
                sda_oe_n      <= 1'b0;                      // RULE_03
                ack_phase_reg <= 1'b1;
                if (shift_reg[0]) begin
                  bs_reg    <= BS_READ;
                  shift_reg <= status_byte;                 // RULE_07
                end else begin
                  bs_reg <= BS_SUB;
                end
              end else begin
                bs_reg <= BS_IDLE;
              end
            end
            BS_SUB: begin
              sub_reg       <= shift_reg;
              sda_oe_n      <= 1'b0;  // RULE_03
              ack_phase_reg <= 1'b1;
              bs_reg        <= BS_DATA;
            end
            BS_DATA: begin
              sda_oe_n      <= 1'b0;  // RULE_03
              ack_phase_reg <= 1'b1;
              // only the one implemented location is kept
              if (sub_reg == `PMSC_SUBADDR_BUCK) begin
                hold_data_reg  <= shift_reg; // RULE_04
                hold_valid_reg <= 1'b1;
              end
              bs_reg <= BS_IDLE; // RULE_01
            end
            default: bs_reg <= BS_IDLE;
          endcase
          bit_cnt_reg <= 4'h0;
        end
      end
    end
  end

  // active command latches, loaded at STOP only, cleared on UVLO or power-down
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buck1_light_load_sel <= 1'b0; // RULE_08
      buck2_light_load_sel <= 1'b0;
      buck3_light_load_sel <= 1'b0;
      slew_sel_lsb         <= 1'b0;
      slew_sel_msb         <= 1'b0;
    end else if (clear_regs) begin
      buck1_light_load_sel <= 1'b0; // RULE_08
      buck2_light_load_sel <= 1'b0;
      buck3_light_load_sel <= 1'b0;
      slew_sel_lsb         <= 1'b0;
      slew_sel_msb         <= 1'b0;
    end else if (stop_c && hold_valid_reg) begin // RULE_05
      // bits 0, 1 and 7 stay in hold_data_reg and are not copied to any active latch
      buck1_light_load_sel <= hold_data_reg[`PMSC_B_BK1_LL];   // RULE_10 RULE_09
      buck2_light_load_sel <= hold_data_reg[`PMSC_B_BK2_LL];   // RULE_10
      buck3_light_load_sel <= hold_data_reg[`PMSC_B_BK3_LL];   // RULE_10
      slew_sel_lsb         <= hold_data_reg[`PMSC_B_SLEW_LSB]; // RULE_11
      slew_sel_msb         <= hold_data_reg[`PMSC_B_SLEW_MSB]; // RULE_11
    end
  end

  // pushbutton machine
  reg [31:0] btn_cnt_reg;
  reg [31:0] st_cnt_reg;
  reg        btn_ev_reg;   // button held 50ms (one pulse)
  reg        btn_armed_reg;
  reg        hold_d_reg;
  reg [31:0] pb_low_cnt_reg;

  wire btn_held = pressed && (btn_cnt_reg == CYC_50MS - 1);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      btn_cnt_reg <= 32'h0;
    end else if (!pressed) begin
      btn_cnt_reg <= 32'h0;
    end else if (btn_cnt_reg < CYC_50MS) begin
      btn_cnt_reg <= btn_cnt_reg + 32'h1; // RULE_25
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_state      <= ST_OFF; // RULE_16
      st_cnt_reg    <= 32'h0;
      btn_armed_reg <= 1'b1;
      hold_d_reg    <= 1'b0;
      btn_ev_reg    <= 1'b0;
      ldo2_en       <= 1'b0;
      buck1_en      <= 1'b0;
      buck2_en      <= 1'b0;
    end else begin
      hold_d_reg <= hold;
      btn_ev_reg <= btn_held;
      // a press held through power-down must be released first
      if (!pressed && pm_state != ST_DOWN)
        btn_armed_reg <= 1'b1;
      case (pm_state)
        ST_OFF: begin
          st_cnt_reg <= 32'h0;
          if ((btn_ev_reg && btn_armed_reg) || (hold && !hold_d_reg)) // RULE_16
            pm_state <= ST_UP;
        end
        ST_UP: begin
          st_cnt_reg <= st_cnt_reg + 32'h1; // RULE_25
          if (st_cnt_reg == 32'h0)
            ldo2_en <= 1'b1;              // RULE_17
          if (st_cnt_reg == SEQ_STEP)
            buck1_en <= 1'b1;             // RULE_17
          if (st_cnt_reg == 2 * SEQ_STEP)
            buck2_en <= 1'b1;             // RULE_17
          if (st_cnt_reg == CYC_1S - 1) begin
            st_cnt_reg <= 32'h0;
            pm_state   <= ST_ON;          // RULE_18
          end
        end
        ST_ON: begin
          ldo2_en  <= 1'b1;
          buck1_en <= 1'b1;
          buck2_en <= 1'b1;
          if (!hold || vout_low) begin     // RULE_19 RULE_18
            pm_state <= ST_DOWN;
            ldo2_en  <= 1'b0;              // RULE_20
            buck1_en <= 1'b0;
            buck2_en <= 1'b0;
          end
        end
        ST_DOWN: begin
          ldo2_en       <= 1'b0;
          buck1_en      <= 1'b0;
          buck2_en      <= 1'b0;
          btn_armed_reg <= 1'b0;           // RULE_24
          st_cnt_reg    <= st_cnt_reg + 32'h1;
          if (st_cnt_reg == CYC_1S - 1) begin // RULE_20
            st_cnt_reg <= 32'h0;
            pm_state   <= ST_OFF;
          end
        end
        default: pm_state <= ST_OFF;
      endcase
    end
  end

  // buck3 and button status
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buck3_en          <= 1'b0;
      button_status_out <= 1'b1;
      pb_low_cnt_reg    <= 32'h0;
    end else begin
      buck3_en <= b3_request && (pm_state == ST_UP || pm_state == ST_ON); // RULE_21
      if (button_status_out) begin
        pb_low_cnt_reg <= 32'h0;
        if (btn_held)
          button_status_out <= 1'b0;       // RULE_22
      end else begin
        if (pb_low_cnt_reg < CYC_50MS)
          pb_low_cnt_reg <= pb_low_cnt_reg + 32'h1;
        if (!pressed && pb_low_cnt_reg >= CYC_50MS - 1)
          button_status_out <= 1'b1;       // RULE_22
      end
    end
  end

endmodule // pmsc_top

// ===== common/pmsc_defines.vh
`ifndef PMSC_DEFINES_VH
`define PMSC_DEFINES_VH
// serial port
`define PMSC_SLAVE_ADDR      7'h09
`define PMSC_SUBADDR_BUCK    8'h00
`define PMSC_BUCK_RESET      8'h00
// buck control field positions
`define PMSC_B_BK1_LL        2
`define PMSC_B_BK2_LL        3
`define PMSC_B_BK3_LL        4
`define PMSC_B_SLEW_LSB      5
`define PMSC_B_SLEW_MSB      6
// status field positions
`define PMSC_A_CHARGING      0
`define PMSC_A_FAULT_LSB     1
`define PMSC_A_LDO1_GOOD     3
// timing
`define PMSC_CLK_MHZ         100
`define PMSC_T50_MS          50
`define PMSC_T1S_MS          1000
`define PMSC_CYC_50MS        (`PMSC_T50_MS * 1000 * `PMSC_CLK_MHZ)
`define PMSC_CYC_1S          (`PMSC_T1S_MS * 1000 * `PMSC_CLK_MHZ)
// sequencing step between successive regulator enables
`define PMSC_SEQ_STEP        16
`endif

// ===== dv/pmsc_host.sv
`timescale 1ns/1ns
module pmsc_host (
  output logic scl,   // bus clock
  output logic sda_m, // data drive, 1 releases
  input  wire  sda    // resolved data line
);
  // all steps are multiples of 5 ns so no change lands on a ref_clk edge
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #30 scl = 1'b1;
    #30 r = sda;
    #30 scl = 1'b0;
    #35;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #30 scl = 1'b1;
    #60 sda_m = 1'b0;
    #60 scl = 1'b0;
    #30;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #30 scl = 1'b1;
    #60 sda_m = 1'b1;
    #60;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // master never acknowledges the status byte
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
endmodule // pmsc_host

// ===== dv/pmsc_top_monitor.sv
`timescale 1ns/1ns
module pmsc_top_monitor #(
  parameter CYC_1S = 200
) (
  input logic       ref_clk,               // clock
  input logic       reset_n,               // reset
  input logic       interface_supply_uvlo, // clear
  input logic       scl_in,                // bus clock
  input logic       sda_oe_n,              // data drive
  input logic       button_n_in,           // button
  input logic       power_hold_in,         // hold
  input logic       ldo2_en,               // enable
  input logic       buck1_en,              // enable
  input logic       buck2_en,              // enable
  input logic       buck3_en,              // enable
  input logic       button_status_out,     // status
  input logic       buck1_light_load_sel,  // latch
  input logic       buck2_light_load_sel,  // latch
  input logic       buck3_light_load_sel,  // latch
  input logic       slew_sel_lsb,          // latch
  input logic       slew_sel_msb,          // latch
  input logic [3:0] pm_state               // state
);
  localparam int T_LO = CYC_1S - 1;
  localparam int T_HI = CYC_1S + 1;
  wire [4:0] lat = {slew_sel_msb, slew_sel_lsb, buck3_light_load_sel, buck2_light_load_sel,
                    buck1_light_load_sel};
  wire [3:0] ens = {ldo2_en, buck1_en, buck2_en, buck3_en};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_off; $past(pm_state) == 4'h1 && pm_state != 4'h1 |-> pm_state == 4'h2; endproperty
  a_off: assert property (p_off) else $error("bad exit from off");
  property p_seq; $rose(buck1_en) |-> $past(ldo2_en, 3) ##[1:20] $rose(buck2_en); endproperty
  a_seq: assert property (p_seq) else $error("enable order wrong");
  property p_up; $rose(pm_state[1]) |-> ##[T_LO:T_HI] $fell(pm_state[1]); endproperty
  a_up: assert property (p_up) else $error("power-up length wrong");
  property p_dn; $rose(pm_state[3]) |-> ##[T_LO:T_HI] $fell(pm_state[3]); endproperty
  a_dn: assert property (p_dn) else $error("power-down length wrong");
  property p_clr; pm_state[3] ##1 pm_state[3] |-> ens == 4'h0 && lat == 5'h00; endproperty
  a_clr: assert property (p_clr) else $error("not cleared in power-down");
  property p_b3; !pm_state[1] && !pm_state[2] ##1 !pm_state[1] && !pm_state[2] |-> !buck3_en;
  endproperty
  a_b3: assert property (p_b3) else $error("buck3 on outside up");
  property p_hold; pm_state[2] && !power_hold_in |-> ##[0:6] pm_state[3]; endproperty
  a_hold: assert property (p_hold) else $error("no power-down on hold low");
  // outside power-down and UVLO, latches move only after a stop, which leaves the bus clock high
  property p_stop;
    $changed(lat) && !pm_state[3] && !interface_supply_uvlo && !$past(interface_supply_uvlo)
      |-> scl_in;
  endproperty
  a_stop: assert property (p_stop) else $error("latch moved without stop");
  property p_ack; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_ack: assert property (p_ack) else $error("data drive moved with clock high");
  property p_bst;
    $fell(button_status_out) |-> !$past(button_n_in, 16) ##1 !button_status_out [*8];
  endproperty
  a_bst: assert property (p_bst) else $error("button status timing wrong");
  c_lat: cover property ($changed(lat));
  c_on: cover property ($rose(pm_state[2]));
  c_dn: cover property ($rose(pm_state[3]));
endmodule // pmsc_top_monitor
bind pmsc_top pmsc_top_monitor #(.CYC_1S(CYC_1S)) u_mon (.ref_clk, .reset_n,
  .interface_supply_uvlo, .scl_in, .sda_oe_n, .button_n_in, .power_hold_in, .ldo2_en,
  .buck1_en, .buck2_en, .buck3_en, .button_status_out, .buck1_light_load_sel,
  .buck2_light_load_sel, .buck3_light_load_sel, .slew_sel_lsb, .slew_sel_msb, .pm_state);

// ===== dv/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       interface_supply_uvlo = 1'b0;
  logic       button_n_in = 1'b1;
  logic       power_hold_in = 1'b0;
  logic       buck3_enable_in = 1'b0;
  logic       vout_uvlo = 1'b0;
  logic [4:0] supply_good_in = 5'h00;
  logic [1:0] charger_fault_in = 2'h0;
  logic       charging_in = 1'b0;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  wire        scl_in, sda_m, sda_out, sda_oe_n, ldo2_en, buck1_en, buck2_en, buck3_en;
  wire        button_status_out, buck1_light_load_sel, buck2_light_load_sel;
  wire        buck3_light_load_sel, slew_sel_lsb, slew_sel_msb;
  wire [3:0]  pm_state;
  wire        sda_in = sda_m & (sda_oe_n | sda_out);
  wire [4:0]  lat = {slew_sel_msb, slew_sel_lsb, buck3_light_load_sel, buck2_light_load_sel,
                     buck1_light_load_sel};
  always #5 ref_clk = ~ref_clk;
  pmsc_host host (.scl(scl_in), .sda_m, .sda(sda_in));
  pmsc_top #(.CYC_50MS(20), .CYC_1S(200), .SEQ_STEP(4)) DUT (.ref_clk, .reset_n,
    .interface_supply_uvlo, .scl_in, .sda_in, .sda_out, .sda_oe_n, .button_n_in,
    .power_hold_in, .buck3_enable_in, .vout_uvlo, .supply_good_in, .charger_fault_in,
    .charging_in, .ldo2_en, .buck1_en, .buck2_en, .buck3_en, .button_status_out,
    .buck1_light_load_sel, .buck2_light_load_sel, .buck3_light_load_sel, .slew_sel_lsb,
    .slew_sel_msb, .pm_state);
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_st(input logic [3:0] s, input int n);
    for (int i = 0; i < n && pm_state !== s; i++) tick(1);
    `CHK("pm_state", s, pm_state)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d);
    logic k;
    host.start();
    host.wbyte(a, k);
    `CHK("addr_ack", a == 8'h12, k)
    if (k) begin
      host.wbyte(s, k);
      `CHK("sub_ack", 1'b1, k)
      host.wbyte(d, k);
      `CHK("data_ack", 1'b1, k)
    end
  endtask
  task automatic wrs(input logic [7:0] d);
    wr(8'h12, 8'h00, d);
    host.stop();
    tick(6);
    `CHK("latch", d[6:2], lat)
  endtask
  task automatic t_write();
    logic [7:0] d;
    logic [4:0] e;
    logic       k;
    e = 5'h00;
    for (int i = 0; i < 4; i++) begin
      d = {~i[0], i[1:0], i[0] ? 3'b101 : 3'b010, 2'b11};
      wr(8'h12, 8'h00, d);
      `CHK("held", e, lat)
      host.start();
      host.wbyte(8'h40, k);
      `CHK("other_ack", 1'b0, k)
      host.stop();
      tick(6);
      e = d[6:2];
      `CHK("latch", e, lat)
    end
    e = 5'h09;
    wr(8'h12, 8'h00, 8'h24);
    wr(8'h14, 8'h00, 8'h00);
    host.stop();
    tick(6);
    `CHK("latch", e, lat)
  endtask
  task automatic t_read();
    logic [7:0] e;
    logic [7:0] r;
    logic       k;
    for (int i = 0; i < 4; i++) begin
      e = {5'(i * 9 + 3), i[1:0], i[0]};
      {supply_good_in, charger_fault_in, charging_in} = e;
      host.start();
      host.wbyte(8'h13, k);
      `CHK("read_ack", 1'b1, k)
      tick(1);
      {supply_good_in, charger_fault_in, charging_in} = ~e;
      host.rbyte(r);
      `CHK("status", e, r)
      if (i[0]) host.stop();
    end
  endtask
  task automatic t_button();
    button_n_in = 1'b0;
    wait_st(4'h2, 40);
    tick(3);
    `CHK("bstat_low", 1'b0, button_status_out)
    button_n_in = 1'b1;
    tick(8);
    `CHK("bstat_min", 1'b0, button_status_out)
    tick(16);
    `CHK("bstat_high", 1'b1, button_status_out)
    `CHK("seq", 3'h7, {ldo2_en, buck1_en, buck2_en})
    power_hold_in = 1'b1;
    buck3_enable_in = 1'b1;
    tick(4);
    `CHK("b3_up", 1'b1, buck3_en)
    wait_st(4'h4, 220);
    wrs(8'hff);
    power_hold_in = 1'b0;
    wait_st(4'h8, 10);
    button_n_in = 1'b0;
    tick(2);
    `CHK("down", 9'h0, {ldo2_en, buck1_en, buck2_en, buck3_en, lat})
    wait_st(4'h1, 220);
    tick(40);
    `CHK("off", 5'h02, {pm_state, buck3_en})
    button_n_in = 1'b1;
    buck3_enable_in = 1'b0;
  endtask
  task automatic t_hold();
    power_hold_in = 1'b1;
    wait_st(4'h2, 10);
    power_hold_in = 1'b0;
    wait_st(4'h8, 230);
    wait_st(4'h1, 220);
    power_hold_in = 1'b1;
    wait_st(4'h4, 240);
    wrs(8'h1c);
    interface_supply_uvlo = 1'b1;
    tick(3);
    `CHK("uvlo", 5'h00, lat)
    interface_supply_uvlo = 1'b0;
    vout_uvlo = 1'b1;
    wait_st(4'h8, 10);
    vout_uvlo = 1'b0;
    power_hold_in = 1'b0;
    wait_st(4'h1, 220);
  endtask
  task automatic test_done();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    tick(10);
    reset_n = 1'b1;
    tick(4);
    `CHK("reset", 12'h880, {button_status_out, pm_state, ldo2_en, buck3_en, lat})
    t_write();
    t_read();
    t_button();
    t_hold();
    test_done();
  end
  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end
endmodule // testbench
